// ---- src/pmbus_sup_pkg.sv ----
// pmbus_sup_pkg: constants for the bus target supervision block
// assumes a 50 MHz core clock and no software-visible registers
`default_nettype none
package pmbus_sup_pkg;
  localparam int unsigned CLK_HZ          = 50_000_000;
  // stuck-bus windows, milliseconds
  localparam int unsigned NONBLOCK_MS     = 32;
  localparam int unsigned BLOCK_MS        = 150;
  // longest times round down to whole cycles
  localparam int unsigned NONBLOCK_CYC    = (CLK_HZ / 1000) * NONBLOCK_MS;
  localparam int unsigned BLOCK_CYC       = (CLK_HZ / 1000) * BLOCK_MS;
  // linear number format fields
  localparam int unsigned EXP_W           = 5;
  localparam int unsigned MANT_W          = 11;
  localparam int unsigned LIN_W           = EXP_W + MANT_W;
  localparam int unsigned RES_BITS        = 10;
  localparam int unsigned RAW_W           = 32;
  // largest exponent that stays positive in the signed field
  localparam int unsigned EXP_MAX         = (1 << (EXP_W - 1)) - 1;
  localparam int unsigned MANT_LIM        = 1 << RES_BITS;
  // target address
  localparam int unsigned ADDR_W          = 7;
  localparam int unsigned STRAP_W         = 4;
  localparam logic [6:0]  NVM_ADDR_RST    = 7'h40;
  localparam int unsigned TIMER_W         = 24;
endpackage
`default_nettype wire

// ---- src/pmbus_target_supervision.sv ----
// pmbus_target_supervision: stuck-bus timer, address select, write guard,
// alert pin driver and linear-format encoder around a bus target port.
// assumes the protocol engine reports starts/stops on the core clock and
// a strap decoder gives a level plus an open-pin flag.
//
// What this block does
// - non-block reads abandoned after 32 ms
// - block reads abandoned after 150 ms
// - timeout counted from latest start condition
// - values encoded as 5-bit exp, 11-bit mantissa
// - telemetry limited to 10 bits resolution
// - address low four bits from strap
// - open strap falls back to stored address
// - write-protect high blocks protected writes
// - open-drain alert pulled low when active
`timescale 1ns/1ps
`default_nettype none
module pmbus_target_supervision #(
  parameter int unsigned NONBLOCK_CYCLES = pmbus_sup_pkg::NONBLOCK_CYC,
  parameter int unsigned BLOCK_CYCLES    = pmbus_sup_pkg::BLOCK_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // protocol engine events (same clock)
  input  wire logic        start_seen,
  input  wire logic        stop_seen,
  input  wire logic        block_read,
  input  wire logic        eng_sda_low,
  input  wire logic        wr_req,
  input  wire logic        wr_protected,
  // pins
  input  wire logic        write_protect_pin,
  input  wire logic [3:0]  address_strap_input,
  input  wire logic        strap_open,
  input  wire logic [6:0]  nvm_addr,
  input  wire logic        alert_req,
  // telemetry in
  input  wire logic [31:0] raw_value,
  input  wire logic        raw_valid,
  // outputs
  output logic             sda_o,
  output logic             sda_oe,
  output logic             alert_o,
  output logic             alert_oe,
  output logic             stuck_bus_timeout,
  output logic             wr_accept,
  output logic [6:0]       target_addr,
  output logic [15:0]      lin_word,
  output logic             lin_valid
);
  // elaboration check: the timer must hold the longer window
  if (NONBLOCK_CYCLES < 1 || BLOCK_CYCLES <= NONBLOCK_CYCLES ||
      BLOCK_CYCLES >= (1 << pmbus_sup_pkg::TIMER_W)) begin : g_bad_cycles
    $error("bad stuck-bus cycle counts");
  end
  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: two flops, first read by nothing else
  logic [1:0] wp_s_r, wp_s_nxt;
  logic [3:0] st0_r, st1_r;
  logic       op0_r, op1_r, al0_r, al1_r;
  always_comb wp_s_nxt = {wp_s_r[0], write_protect_pin};
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_s_r <= 2'h3;
      st0_r  <= 4'h0;
      st1_r  <= 4'h0;
      op0_r  <= 1'h1;
      op1_r  <= 1'h1;
      al0_r  <= 1'h0;
      al1_r  <= 1'h0;
    end else begin
      wp_s_r <= wp_s_nxt;
      st0_r  <= address_strap_input;
      st1_r  <= st0_r;
      op0_r  <= strap_open;
      op1_r  <= op0_r;
      al0_r  <= alert_req;
      al1_r  <= al0_r;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // stuck-bus timer
  typedef enum logic [1:0] {IDLE, BUSY, STUCK} tmr_t;
  tmr_t                                 st_r, st_nxt;
  logic [pmbus_sup_pkg::TIMER_W-1:0]    cnt_r, cnt_nxt;
  logic [pmbus_sup_pkg::TIMER_W-1:0]    limit;
  logic                                 to_pulse;
  always_comb begin
    limit    = block_read ? BLOCK_CYCLES[pmbus_sup_pkg::TIMER_W-1:0]
                          : NONBLOCK_CYCLES[pmbus_sup_pkg::TIMER_W-1:0];
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    to_pulse = 1'b0;
    case (st_r)
      IDLE: if (start_seen) begin
        st_nxt  = BUSY;
        cnt_nxt = '0;
      end
      BUSY: begin
        if (start_seen) begin
          cnt_nxt = '0;
        end else if (stop_seen) begin
          st_nxt = IDLE;
        end else if (cnt_r + 1'b1 >= limit) begin
          st_nxt   = STUCK;
          to_pulse = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      STUCK: if (start_seen) begin
        st_nxt  = BUSY;
        cnt_nxt = '0;
      end
      default: st_nxt = IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r              <= IDLE;
      cnt_r             <= '0;
      stuck_bus_timeout <= 1'b0;
    end else begin
      st_r              <= st_nxt;
      cnt_r             <= cnt_nxt;
      stuck_bus_timeout <= to_pulse;
    end
  end
  nb_timeout_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == BUSY && !block_read && !start_seen && !stop_seen &&
     cnt_r + 1'b1 >= NONBLOCK_CYCLES) |=> stuck_bus_timeout)
    else $error("non-block timeout missed");
  blk_timeout_a: assert property (@(posedge clk) disable iff (rst)
    (st_r == BUSY && block_read && cnt_r < BLOCK_CYCLES - 2) |=> !stuck_bus_timeout)
    else $error("block read timed out early");
  restart_cnt_a: assert property (@(posedge clk) disable iff (rst)
    (start_seen) |=> (cnt_r == '0 && st_r == BUSY))
    else $error("timer not restarted on start");
  // bus released while stuck, engine drives otherwise
  always_comb begin
    sda_o  = 1'b0;
    sda_oe = eng_sda_low && (st_r != STUCK) && !to_pulse;
  end
  // a start in the pulse cycle legally hands the bus back to the engine
  release_a: assert property (@(posedge clk) disable iff (rst)
    stuck_bus_timeout && !start_seen |-> !sda_oe [*2])
    else $error("sda held after timeout");
  pulse_once_a: assert property (@(posedge clk) disable iff (rst)
    stuck_bus_timeout |=> !stuck_bus_timeout)
    else $error("timeout pulse too long");
  //////////////////////////////////////////////////////////////////////////////
  // address select and write guard; strap level re-sampled every cycle after reset release
  logic [6:0] addr_nxt;
  always_comb begin
    if (op1_r) addr_nxt = nvm_addr;
    else addr_nxt = {nvm_addr[6:4], st1_r};
  end
  always_ff @(posedge clk) begin
    if (rst) target_addr <= pmbus_sup_pkg::NVM_ADDR_RST;
    else     target_addr <= addr_nxt;
  end
  always_comb wr_accept = wr_req && !(wp_s_r[1] && wr_protected);
  strap_addr_a: assert property (@(posedge clk) disable iff (rst)
    !op1_r ##1 1'b1 |-> target_addr[3:0] == $past(st1_r))
    else $error("strap bits not used");
  nvm_addr_a: assert property (@(posedge clk) disable iff (rst)
    op1_r |=> target_addr == $past(nvm_addr))
    else $error("stored address not used");
  wr_guard_a: assert property (@(posedge clk) disable iff (rst)
    (wp_s_r[1] && wr_protected) |-> !wr_accept)
    else $error("protected write passed");
  // open drain: low while alert active
  always_comb begin
    alert_o  = 1'b0;
    alert_oe = al1_r;
  end
  alert_drv_a: assert property (@(posedge clk) disable iff (rst)
    alert_req ##2 alert_req |-> alert_oe && !alert_o)
    else $error("alert not pulled low");
  //////////////////////////////////////////////////////////////////////////////
  // linear encoder: shift unsigned raw into 10 magnitude bits plus sign
  // truncation, not rounding: cheaper, at most one lsb low
  // exponent kept positive in its signed field; above that the mantissa saturates
  typedef logic [pmbus_sup_pkg::EXP_W-1:0]    exp_t;
  typedef logic [pmbus_sup_pkg::RES_BITS-1:0] mant_t;
  logic [15:0] lin_nxt;
  exp_t        sh;
  mant_t       mant;
  always_comb begin
    sh = '0;
    for (int i = 0; i < pmbus_sup_pkg::EXP_MAX; i++) begin
      if ((raw_value >> i) >= pmbus_sup_pkg::MANT_LIM) sh = exp_t'(i + 1);
    end
    if ((raw_value >> sh) >= pmbus_sup_pkg::MANT_LIM) mant = '1;
    else mant = mant_t'(raw_value >> sh);
    lin_nxt = {sh, 1'b0, mant};
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      lin_word  <= 16'h0000;
      lin_valid <= 1'b0;
    end else begin
      if (raw_valid) lin_word <= lin_nxt;
      lin_valid <= raw_valid;
    end
  end
  lin_fmt_a: assert property (@(posedge clk) disable iff (rst)
    raw_valid |=> !lin_word[15] && !lin_word[10] && (lin_word[15:11] == '0 || lin_word[9]))
    else $error("linear word malformed");
  lin_res_a: assert property (@(posedge clk) disable iff (rst)
    raw_valid |=> ($past(raw_value) >> lin_word[15:11]) < pmbus_sup_pkg::MANT_LIM ||
      (lin_word[15:11] == pmbus_sup_pkg::EXP_MAX && lin_word[9:0] == '1))
    else $error("mantissa over ten bits");
  //////////////////////////////////////////////////////////////////////////////
  // scenario covers
  cov_timeout_c: cover property (@(posedge clk) stuck_bus_timeout);
  cov_stop_c: cover property (@(posedge clk) st_r == BUSY ##1 st_r == IDLE);
  cov_wp_c: cover property (@(posedge clk) wr_req && !wr_accept);
  cov_blk_c: cover property (@(posedge clk) stuck_bus_timeout && block_read);
  cov_sat_c: cover property (@(posedge clk) lin_valid && lin_word[9:0] == '1);
endmodule // pmbus_target_supervision
`default_nettype wire

// ---- sim/host_model.sv ----
// host_model: far-side bus host stand-in, gives start/stop events
// assumes tasks are called by the bench on the clk domain
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input  wire logic clk,
  // bus events toward the block
  output logic      start_seen,
  output logic      stop_seen,
  output logic      block_read,
  output logic      eng_sda_low
);
  initial begin
    start_seen  = 1'b0;
    stop_seen   = 1'b0;
    block_read  = 1'b0;
    eng_sda_low = 1'b0;
  end
  // start pulse, sda held low as if mid-read
  task automatic open_txn(input logic blk);
    @(posedge clk);
    start_seen  <= 1'b1;
    block_read  <= blk;
    eng_sda_low <= 1'b1;
    @(posedge clk);
    start_seen  <= 1'b0;
  endtask
  task automatic close_txn();
    @(posedge clk);
    stop_seen   <= 1'b1;
    eng_sda_low <= 1'b0;
    @(posedge clk);
    stop_seen   <= 1'b0;
  endtask
endmodule // host_model
`default_nettype wire

// ---- sim/pmbus_target_supervision_tb.sv ----
// pmbus_target_supervision_tb: directed scenarios, short timer windows
// assumes host_model for bus events; 20/50 cycle windows stand in for ms
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module pmbus_target_supervision_tb;
  logic clk = 1'b0, rst = 1'b1, wr_req = 1'b0, wr_protected = 1'b0, wp = 1'b0;
  logic [3:0] strap = 4'h0;
  logic strap_open = 1'b0, alert_req = 1'b0, raw_valid = 1'b0;
  logic [6:0] nvm_addr = 7'h35;
  logic [31:0] raw_value = 32'h0;
  logic start_seen, stop_seen, block_read, eng_sda_low, sda_o, sda_oe, alert_o, alert_oe;
  logic stuck_bus_timeout, wr_accept, lin_valid;
  logic [6:0] target_addr;
  logic [15:0] lin_word;
  int n_errors = 0, n_checks = 0;
  initial forever #10 clk = ~clk;
  host_model u_host (.clk(clk), .start_seen(start_seen), .stop_seen(stop_seen),
    .block_read(block_read), .eng_sda_low(eng_sda_low));
  pmbus_target_supervision #(.NONBLOCK_CYCLES(20), .BLOCK_CYCLES(50)) u_dut (
    .clk(clk), .rst(rst), .start_seen(start_seen), .stop_seen(stop_seen),
    .block_read(block_read), .eng_sda_low(eng_sda_low), .wr_req(wr_req),
    .wr_protected(wr_protected), .write_protect_pin(wp), .address_strap_input(strap),
    .strap_open(strap_open), .nvm_addr(nvm_addr), .alert_req(alert_req),
    .raw_value(raw_value), .raw_valid(raw_valid), .sda_o(sda_o), .sda_oe(sda_oe),
    .alert_o(alert_o), .alert_oe(alert_oe), .stuck_bus_timeout(stuck_bus_timeout),
    .wr_accept(wr_accept), .target_addr(target_addr), .lin_word(lin_word),
    .lin_valid(lin_valid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // gap>0 restarts mid-count; stp ends the transfer early
  task automatic timer(input logic blk, input int gap, input logic stp, input int n);
    int c;
    u_host.open_txn(blk);
    if (gap > 0) begin
      repeat (gap) @(posedge clk);
      u_host.open_txn(blk);
    end
    if (stp) u_host.close_txn();
    for (c = 1; c < 80; c++) begin
      settle(1);
      if (c == 1) `CHK(sda_oe, ~stp)
      if (stuck_bus_timeout === 1'b1) break;
    end
    if (n == 0) `CHK(c, 80)
    else begin
      `CHK(c, n)
      `CHK({sda_oe, sda_o}, 2'b00)
      settle(1);
      `CHK({stuck_bus_timeout, sda_oe}, 2'b00)
    end
    u_host.close_txn();
    $display("timer test done");
  endtask
  task automatic enc(input logic [31:0] v, input logic [15:0] w);
    @(posedge clk) raw_value <= v;
    raw_valid <= 1'b1;
    @(posedge clk) raw_valid <= 1'b0;
    #1;
    `CHK(lin_valid, 1'b1)
    `CHK(lin_word, w)
    $display("encoder test done");
  endtask
  task automatic pins();
    @(posedge clk) strap <= 4'ha;
    wp <= 1'b1;
    wr_req <= 1'b1;
    wr_protected <= 1'b1;
    alert_req <= 1'b1;
    settle(4);
    `CHK(target_addr, 7'h3a)
    `CHK(wr_accept, 1'b0)
    `CHK({alert_oe, alert_o}, 2'b10)
    @(posedge clk) strap_open <= 1'b1;
    wp <= 1'b0;
    alert_req <= 1'b0;
    settle(4);
    `CHK(target_addr, 7'h35)
    `CHK(wr_accept, 1'b1)
    `CHK(alert_oe, 1'b0)
    $display("pin test done");
  endtask
  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    close_out();
  end
  initial begin
    settle(19);
    @(posedge clk) rst <= 1'b0;
    settle(3);
    timer(1'b0, 0, 1'b0, 20);
    timer(1'b1, 0, 1'b0, 50);
    timer(1'b0, 15, 1'b0, 20);
    timer(1'b0, 0, 1'b1, 0);
    enc(32'h0000_03ff, 16'h03ff);
    enc(32'h0000_0800, {5'h02, 11'h200});
    enc(32'h00ff_ffff, {5'h0e, 11'h3ff});
    enc(32'h1000_0000, {5'h0f, 11'h3ff});
    pins();
    close_out();
  end
endmodule // pmbus_target_supervision_tb
`default_nettype wire
